// ===== logic/sts_pkg.sv
package sts_pkg;
	// ==========================================================
	// Command codes of the serial management port
	localparam logic [7:0] CMD_STARTUP_DELAY = 8'hd4;
	localparam logic [7:0] CMD_SLEW_SELECT = 8'hd5;
	localparam logic [7:0] CMD_LOADLINE_CAL = 8'hde;
	localparam logic [7:0] CMD_LOADLINE_SET = 8'hdf;
	localparam logic [7:0] CMD_LIMIT_TRIM = 8'he2;
	localparam logic [7:0] CMD_READ_CURRENT = 8'h8c;

	// ==========================================================
	// Field positions and reset values
	localparam int DELAY_CODE_MSB = 2;
	localparam int SLEW_CODE_MSB = 2;
	localparam int TRIM_CODE_MSB = 4;
	localparam logic [2:0] DELAY_CODE_RST = 3'h3;
	localparam logic [2:0] SLEW_CODE_RST = 3'h2;
	localparam logic [4:0] TRIM_CODE_RST = 5'h10;
	localparam logic [4:0] LOADLINE_RST = 5'h10;

	// ==========================================================
	// Timing and levels
	localparam int CLK_PERIOD_NS = 5;
	localparam int DELAY_STEP_US = 500;
	localparam int DELAY_STEP_CYC = DELAY_STEP_US * 1000 / CLK_PERIOD_NS;
	localparam int SLEW_BASE_NS = 62500;
	localparam int SLEW_BASE_CYC = SLEW_BASE_NS / CLK_PERIOD_NS;
	localparam int LATCHOFF_MULT = 4;
	localparam int DETECT_CYC = 6;
	localparam logic [7:0] BOOT_DAC_CODE = 8'ha8;
	localparam int TMR_W = 24;

	typedef enum logic [3:0] {
		ST_IDLE, ST_DELAY, ST_DETECT, ST_BOOT_RAMP, ST_BOOT_HOLD,
		ST_FINAL_RAMP, ST_BLANK, ST_RUN, ST_LATCH_WAIT, ST_LATCHED
	} sts_state_t;
endpackage

// ===== logic/sts_tmr_if.sv
interface sts_tmr_if;
	logic start;
	logic stop;
	logic long_mode;
	logic [2:0] code;
	logic done;
	logic busy;
	modport ctrl (output start, output stop, output long_mode, output code, input done, input busy);
	modport tmr (input start, input stop, input long_mode, input code, output done, output busy);
endinterface

// ===== logic/sts_delay_timer.sv
module sts_delay_timer #(
	parameter int STEP_CYC = sts_pkg::DELAY_STEP_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	sts_tmr_if.tmr t
);
	// ==========================================================
	// Interval length: code picks 0.5 ms steps, long mode is four times that
	function automatic logic [sts_pkg::TMR_W-1:0] load_val(input logic [2:0] code, input logic lng);
		logic [sts_pkg::TMR_W-1:0] base;
		base = sts_pkg::TMR_W'(({29'h0, code} + 32'h1) * STEP_CYC);
		if (lng) begin
			base = sts_pkg::TMR_W'(base * sts_pkg::LATCHOFF_MULT);
		end
		return base - sts_pkg::TMR_W'(1);
	endfunction

	logic [sts_pkg::TMR_W-1:0] cnt_r;
	logic busy_r;
	logic done_r;

	// Code is sampled only at start, so a rewrite never bends a running interval
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (t.stop) begin
				busy_r <= 1'b0;
			end else if (t.start) begin
				cnt_r <= load_val(t.code, t.long_mode);
				busy_r <= 1'b1;
			end else if (busy_r) begin
				if (cnt_r == '0) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r - sts_pkg::TMR_W'(1);
				end
			end
		end
	end

	assign t.busy = busy_r;
	assign t.done = done_r;
endmodule

// ===== logic/sts_sequencer.sv
module sts_sequencer #(
	parameter int DELAY_STEP_CYC = sts_pkg::DELAY_STEP_CYC,
	parameter int SLEW_BASE_CYC = sts_pkg::SLEW_BASE_CYC
) (
	input wire logic REF_CLK_I,
	input wire logic RST_B_I,
	input wire logic EN_I,
	input wire logic SUPPLY_LOCKOUT_I,
	input wire logic [3:0] PHASE_ABOVE_THR_I,
	input wire logic CUR_LIMIT_I,
	input wire logic [7:0] VOLTAGE_ID_CODE_I,
	input wire logic [3:0] PHASE_PWM_REQ_I,
	input wire logic [7:0] SENSE_CURRENT_I,
	input wire logic CMD_WR_I,
	input wire logic CMD_RD_I,
	input wire logic [7:0] CMD_CODE_I,
	input wire logic [7:0] CMD_WDATA_I,
	output logic [7:0] CMD_RDATA_O,
	output logic [3:0] PHASE_DRIVE_O,
	output logic [3:0] PHASE_DRIVE_OE_O,
	output logic [3:0] PHASE_PULLDOWN_O,
	output logic [3:0] PHASE_SLOT_O,
	output logic [2:0] PHASE_COUNT_O,
	output logic [7:0] DAC_CODE_O,
	output logic [4:0] LIMIT_TRIM_O,
	output logic [4:0] LOADLINE_CAL_O,
	output logic [4:0] LOADLINE_SET_O,
	output logic POWER_GOOD_O,
	output logic LATCHOFF_O
);
	// ==========================================================
	// Decoders
	function automatic logic [3:0] tied_of(input logic [3:0] hi);
		if (hi[3:1] == 3'h7) begin
			return 4'he;
		end else if (hi[3:2] == 2'h3) begin
			return 4'hc;
		end else if (hi[3]) begin
			return 4'h8;
		end
		return 4'h0;
	endfunction

	function automatic logic [2:0] count_of(input logic [3:0] tied);
		return 3'h4 - 3'(tied[1]) - 3'(tied[2]) - 3'(tied[3]);
	endfunction

	function automatic logic [sts_pkg::TMR_W-1:0] slew_cyc(input logic [2:0] code);
		return sts_pkg::TMR_W'(SLEW_BASE_CYC / (2 * int'(code) + 1));
	endfunction

	// ==========================================================
	// Pin synchronisers: first stage feeds only the second
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= {CUR_LIMIT_I, SUPPLY_LOCKOUT_I, EN_I, PHASE_ABOVE_THR_I};
			sync2_r <= sync1_r;
		end
	end
	logic [3:0] hi_s;
	logic en_s;
	logic lock_s;
	logic ilim_s;
	assign hi_s = sync2_r[3:0];
	assign en_s = sync2_r[4];
	assign lock_s = sync2_r[5];
	assign ilim_s = sync2_r[6];

	// ==========================================================
	// Command registers
	logic [2:0] delay_code_r;
	logic [2:0] slew_code_r;
	logic [4:0] trim_r;
	logic [4:0] ll_cal_r;
	logic [4:0] ll_set_r;
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			delay_code_r <= sts_pkg::DELAY_CODE_RST;
			slew_code_r <= sts_pkg::SLEW_CODE_RST;
			trim_r <= sts_pkg::TRIM_CODE_RST;
			ll_cal_r <= sts_pkg::LOADLINE_RST;
			ll_set_r <= sts_pkg::LOADLINE_RST;
		end else if (CMD_WR_I) begin
			unique case (CMD_CODE_I)
				sts_pkg::CMD_STARTUP_DELAY: delay_code_r <= CMD_WDATA_I[sts_pkg::DELAY_CODE_MSB:0];
				sts_pkg::CMD_SLEW_SELECT: slew_code_r <= CMD_WDATA_I[sts_pkg::SLEW_CODE_MSB:0];
				sts_pkg::CMD_LIMIT_TRIM: trim_r <= CMD_WDATA_I[sts_pkg::TRIM_CODE_MSB:0];
				sts_pkg::CMD_LOADLINE_CAL: ll_cal_r <= CMD_WDATA_I[4:0];
				sts_pkg::CMD_LOADLINE_SET: ll_set_r <= CMD_WDATA_I[4:0];
				default: ;
			endcase
		end
	end

	// Read data is registered; unknown codes answer zero
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			CMD_RDATA_O <= 8'h00;
		end else if (CMD_RD_I) begin
			unique case (CMD_CODE_I)
				sts_pkg::CMD_STARTUP_DELAY: CMD_RDATA_O <= {5'h00, delay_code_r};
				sts_pkg::CMD_SLEW_SELECT: CMD_RDATA_O <= {5'h00, slew_code_r};
				sts_pkg::CMD_LIMIT_TRIM: CMD_RDATA_O <= {3'h0, trim_r};
				sts_pkg::CMD_LOADLINE_CAL: CMD_RDATA_O <= {3'h0, ll_cal_r};
				sts_pkg::CMD_LOADLINE_SET: CMD_RDATA_O <= {3'h0, ll_set_r};
				sts_pkg::CMD_READ_CURRENT: CMD_RDATA_O <= SENSE_CURRENT_I;
				default: CMD_RDATA_O <= 8'h00;
			endcase
		end
	end

	// Trim and load-line codes go to the analog scalers
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			LIMIT_TRIM_O <= sts_pkg::TRIM_CODE_RST;
			LOADLINE_CAL_O <= sts_pkg::LOADLINE_RST;
			LOADLINE_SET_O <= sts_pkg::LOADLINE_RST;
		end else begin
			LIMIT_TRIM_O <= trim_r;
			LOADLINE_CAL_O <= ll_cal_r;
			LOADLINE_SET_O <= ll_set_r;
		end
	end

	// ==========================================================
	// Shared delay timer
	sts_tmr_if tmr ();
	sts_delay_timer #(.STEP_CYC(DELAY_STEP_CYC)) u_timer (
		.clk_i(REF_CLK_I),
		.rst_b_i(RST_B_I),
		.t(tmr.tmr)
	);

	// ==========================================================
	// Sequencer
	sts_pkg::sts_state_t state_r;
	logic [2:0] det_cnt_r;
	logic [sts_pkg::TMR_W-1:0] step_cnt_r;
	logic [3:0] tied_r;
	logic oc_seen_r;
	logic tmr_start_r;
	logic tmr_long_r;
	logic go_on;
	logic ramp_tick;
	assign go_on = en_s && !lock_s;
	assign ramp_tick = (step_cnt_r == '0);
	assign tmr.start = tmr_start_r;
	assign tmr.long_mode = tmr_long_r;
	assign tmr.code = delay_code_r;
	assign tmr.stop = !go_on || (state_r == sts_pkg::ST_LATCH_WAIT && !ilim_s);

	// Main startup flow; enable or lockout loss aborts from anywhere
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_r <= sts_pkg::ST_IDLE;
			tmr_start_r <= 1'b0;
			tmr_long_r <= 1'b0;
			det_cnt_r <= '0;
		end else begin
			tmr_start_r <= 1'b0;
			if (!go_on) begin
				state_r <= sts_pkg::ST_IDLE;
			end else begin
				unique case (state_r)
					sts_pkg::ST_IDLE: begin
						state_r <= sts_pkg::ST_DELAY;
						tmr_start_r <= 1'b1;
						tmr_long_r <= 1'b0;
					end
					sts_pkg::ST_DELAY: if (tmr.done) begin
						state_r <= sts_pkg::ST_DETECT;
						det_cnt_r <= '0;
					end
					sts_pkg::ST_DETECT: begin
						det_cnt_r <= det_cnt_r + 3'h1;
						if (det_cnt_r == 3'(sts_pkg::DETECT_CYC - 1)) begin
							state_r <= sts_pkg::ST_BOOT_RAMP;
						end
					end
					sts_pkg::ST_BOOT_RAMP: if (DAC_CODE_O == sts_pkg::BOOT_DAC_CODE) begin
						state_r <= sts_pkg::ST_BOOT_HOLD;
						tmr_start_r <= 1'b1;
					end
					sts_pkg::ST_BOOT_HOLD: if (tmr.done) begin
						state_r <= sts_pkg::ST_FINAL_RAMP;
					end
					sts_pkg::ST_FINAL_RAMP: if (DAC_CODE_O == VOLTAGE_ID_CODE_I) begin
						state_r <= sts_pkg::ST_BLANK;
						tmr_start_r <= 1'b1;
					end
					sts_pkg::ST_BLANK: if (tmr.done) begin
						if (oc_seen_r || ilim_s) begin
							state_r <= sts_pkg::ST_LATCH_WAIT;
							tmr_start_r <= 1'b1;
							tmr_long_r <= 1'b1;
						end else begin
							state_r <= sts_pkg::ST_RUN;
						end
					end
					sts_pkg::ST_RUN: if (ilim_s) begin
						state_r <= sts_pkg::ST_LATCH_WAIT;
						tmr_start_r <= 1'b1;
						tmr_long_r <= 1'b1;
					end
					sts_pkg::ST_LATCH_WAIT: begin
						if (!ilim_s) begin
							state_r <= sts_pkg::ST_RUN;
						end else if (tmr.done) begin
							state_r <= sts_pkg::ST_LATCHED;
						end
					end
					sts_pkg::ST_LATCHED: ;
					// Unused codes of the state register fall back to a safe start
					default: state_r <= sts_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// A limit seen during startup is held until the sequence ends
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			oc_seen_r <= 1'b0;
		end else if (state_r == sts_pkg::ST_IDLE || state_r == sts_pkg::ST_RUN) begin
			oc_seen_r <= 1'b0;
		end else if (ilim_s) begin
			oc_seen_r <= 1'b1;
		end
	end

	// Soft-start DAC stepping; slew code is picked up at each step start
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			DAC_CODE_O <= 8'h00;
			step_cnt_r <= '0;
		end else if (state_r == sts_pkg::ST_IDLE || state_r == sts_pkg::ST_LATCHED) begin
			DAC_CODE_O <= 8'h00;
			step_cnt_r <= '0;
		end else if (state_r == sts_pkg::ST_BOOT_RAMP || state_r == sts_pkg::ST_FINAL_RAMP) begin
			if (!ramp_tick) begin
				step_cnt_r <= step_cnt_r - sts_pkg::TMR_W'(1);
			end else begin
				step_cnt_r <= slew_cyc(slew_code_r) - sts_pkg::TMR_W'(1);
				if (state_r == sts_pkg::ST_BOOT_RAMP && DAC_CODE_O < sts_pkg::BOOT_DAC_CODE) begin
					DAC_CODE_O <= DAC_CODE_O + 8'h01;
				end else if (state_r == sts_pkg::ST_FINAL_RAMP && DAC_CODE_O < VOLTAGE_ID_CODE_I) begin
					DAC_CODE_O <= DAC_CODE_O + 8'h01;
				end else if (state_r == sts_pkg::ST_FINAL_RAMP && DAC_CODE_O > VOLTAGE_ID_CODE_I) begin
					DAC_CODE_O <= DAC_CODE_O - 8'h01;
				end
			end
		end else begin
			step_cnt_r <= '0;
		end
	end

	// ==========================================================
	// Phase detection and phase outputs
	logic detect_open;
	logic drive_ok;
	assign detect_open = (state_r == sts_pkg::ST_IDLE || state_r == sts_pkg::ST_DELAY
		|| state_r == sts_pkg::ST_DETECT);
	assign drive_ok = !detect_open && state_r != sts_pkg::ST_LATCHED;

	// Classification sampled on the last detection cycle; default is four phases
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			tied_r <= 4'h0;
		end else if (state_r == sts_pkg::ST_DETECT && det_cnt_r == 3'(sts_pkg::DETECT_CYC - 1)) begin
			tied_r <= tied_of(hi_s);
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			PHASE_COUNT_O <= 3'h4;
		end else begin
			PHASE_COUNT_O <= count_of(tied_r);
		end
	end

	// Weak sink only while enabled and before detection ends
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			PHASE_PULLDOWN_O <= 4'h0;
		end else begin
			PHASE_PULLDOWN_O <= {{3{en_s && detect_open}}, 1'b0};
		end
	end

	// Each output has its own gate so phases may overlap
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ph
			always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
				if (!RST_B_I) begin
					PHASE_DRIVE_O[gi] <= 1'b0;
					PHASE_DRIVE_OE_O[gi] <= 1'b0;
				end else begin
					PHASE_DRIVE_O[gi] <= drive_ok && !tied_r[gi] && PHASE_PWM_REQ_I[gi];
					if (gi == 0) begin
						PHASE_DRIVE_OE_O[gi] <= 1'b1;
					end else begin
						PHASE_DRIVE_OE_O[gi] <= drive_ok && !tied_r[gi];
					end
				end
			end
		end
	endgenerate

	// Slot rotates over active phases only: per-phase rate is master over count
	logic [1:0] slot_r;
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			slot_r <= 2'h0;
			PHASE_SLOT_O <= 4'h0;
		end else begin
			if (!drive_ok || 3'(slot_r) + 3'h1 >= PHASE_COUNT_O) begin
				slot_r <= 2'h0;
			end else begin
				slot_r <= slot_r + 2'h1;
			end
			PHASE_SLOT_O <= drive_ok ? (4'h1 << slot_r) : 4'h0;
		end
	end

	// Status flags
	always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			POWER_GOOD_O <= 1'b0;
			LATCHOFF_O <= 1'b0;
		end else begin
			POWER_GOOD_O <= (state_r == sts_pkg::ST_RUN || state_r == sts_pkg::ST_LATCH_WAIT);
			LATCHOFF_O <= (state_r == sts_pkg::ST_LATCHED);
		end
	end

	// ==========================================================
	// Assertions
	sequence s_enter_detect;
		state_r == sts_pkg::ST_DELAY && tmr.done;
	endsequence
	sequence s_detect_span;
		(state_r == sts_pkg::ST_DETECT) [*6] ##1 state_r == sts_pkg::ST_BOOT_RAMP;
	endsequence

	// An abort by enable or lockout ends the window early, so it discards the attempt
	a_detect_six: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I || !go_on)
		s_enter_detect |=> s_detect_span)
		else $error("detection window is not six cycles");
	a_detect_sink: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		state_r == sts_pkg::ST_DETECT && en_s |=> PHASE_PULLDOWN_O == 4'he)
		else $error("weak sinks off during detection");
	a_timer_busy: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		state_r inside {sts_pkg::ST_DELAY, sts_pkg::ST_BOOT_HOLD, sts_pkg::ST_BLANK} && !tmr_start_r
		|-> tmr.busy || tmr.done)
		else $error("shared timer idle during a timed interval");
	a_detect_blank: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		state_r == sts_pkg::ST_DETECT |=> PHASE_DRIVE_O == 4'h0 && PHASE_DRIVE_OE_O[0])
		else $error("phase output active during detection");
	a_start_gate: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		state_r == sts_pkg::ST_IDLE && !go_on |=> state_r == sts_pkg::ST_IDLE)
		else $error("startup left idle without enable");
	a_boot_stop: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		state_r == sts_pkg::ST_BOOT_RAMP |-> DAC_CODE_O <= sts_pkg::BOOT_DAC_CODE)
		else $error("boot ramp passed boot level");
	a_step_size: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		state_r == sts_pkg::ST_FINAL_RAMP && $past(state_r) == sts_pkg::ST_FINAL_RAMP
		|-> DAC_CODE_O - $past(DAC_CODE_O) inside {8'h00, 8'h01, 8'hff})
		else $error("dac moved more than one step");
	a_hold_timer: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		state_r == sts_pkg::ST_BOOT_RAMP && DAC_CODE_O == sts_pkg::BOOT_DAC_CODE && go_on
		|=> tmr_start_r && !tmr_long_r)
		else $error("boot hold timer not started");
	a_latch_long: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		state_r == sts_pkg::ST_RUN && ilim_s && go_on |=> tmr_start_r && tmr_long_r)
		else $error("latchoff timer not started in long mode");
	a_no_early_latch: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		state_r == sts_pkg::ST_LATCH_WAIT |-> $past(state_r) inside {sts_pkg::ST_BLANK, sts_pkg::ST_RUN,
		sts_pkg::ST_LATCH_WAIT})
		else $error("latchoff began before blanking ended");
	a_tied_hiz: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
		state_r == sts_pkg::ST_RUN && $past(state_r) == sts_pkg::ST_RUN
		|-> (PHASE_DRIVE_OE_O[3:1] & tied_r[3:1]) == 3'h0 && PHASE_PULLDOWN_O == 4'h0)
		else $error("tied output driven or still pulled down");
endmodule

// ===== bench/sts_pins_model.sv
// ==========================================================
// Far side of the phase pins: supply ties, weak sinks, floating lines
module sts_pins_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] tie_i,
	input wire logic [3:0] drive_i,
	input wire logic [3:0] oe_i,
	input wire logic [3:0] pulldown_i,
	output logic [3:0] above_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] float_r;

	// A released pin wanders so that a stale level never passes for a real one
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			float_r <= 4'h5;
		end else begin
			float_r <= ~float_r;
		end
	end

	// Comparator view of each pin: supply tie wins over everything
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (tie_i[i]) begin
				above_o[i] = 1'b1;
			end else if (oe_i[i]) begin
				above_o[i] = drive_i[i];
			end else if (pulldown_i[i]) begin
				above_o[i] = 1'b0;
			end else begin
				above_o[i] = float_r[i];
			end
		end
	end
endmodule

// ===== bench/sts_sequencer_bench.sv
// ==========================================================
// Self-checking bench of the startup sequencer
module sts_sequencer_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int STEP = 20;
	localparam int BASE = 10;
	localparam int LIM = 5000;
	logic clk = 1'b0, rst_b = 1'b0, en = 1'b0, lock = 1'b0, climit = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0;
	logic [7:0] voltage_id_code = 8'h80, sense = 8'h00, cmd_code = 8'h00, cmd_wdata = 8'h00;
	logic [3:0] req = 4'h0, tie = 4'h0, above;
	logic [7:0] rdata, dac;
	logic [3:0] drive, oe, pd, slot, act;
	logic [2:0] cnt;
	logic [4:0] trim, llc, lls;
	logic pg, latch, rd_seen = 1'b0;
	logic [31:0] rng = 32'd24248, v;
	logic [7:0] exp_q[$];
	logic [7:0] pv, codes[3] = '{8'he2, 8'hde, 8'hdf};
	logic [3:0] ties[4] = '{4'h0, 4'h8, 4'hc, 4'he};
	logic [3:0] sl_a[8];
	logic [2:0] dlys[4] = '{3'h0, 3'h7, 3'h0, 3'h0};
	logic [2:0] slews[4] = '{3'h2, 3'h2, 3'h2, 3'h0};
	logic [2:0] cnts[4] = '{3'h4, 3'h3, 3'h2, 3'h1};
	int mismatches = 0, checks = 0, n, i, k, t0, t1, tp, b0, bp;

	always #2.5 clk = ~clk;

	sts_sequencer #(.DELAY_STEP_CYC(STEP), .SLEW_BASE_CYC(BASE)) u_dut (
		.REF_CLK_I(clk), .RST_B_I(rst_b), .EN_I(en), .SUPPLY_LOCKOUT_I(lock),
		.PHASE_ABOVE_THR_I(above), .CUR_LIMIT_I(climit), .VOLTAGE_ID_CODE_I(voltage_id_code),
		.PHASE_PWM_REQ_I(req), .SENSE_CURRENT_I(sense), .CMD_WR_I(cmd_wr), .CMD_RD_I(cmd_rd),
		.CMD_CODE_I(cmd_code), .CMD_WDATA_I(cmd_wdata), .CMD_RDATA_O(rdata), .PHASE_DRIVE_O(drive),
		.PHASE_DRIVE_OE_O(oe), .PHASE_PULLDOWN_O(pd), .PHASE_SLOT_O(slot), .PHASE_COUNT_O(cnt),
		.DAC_CODE_O(dac), .LIMIT_TRIM_O(trim), .LOADLINE_CAL_O(llc), .LOADLINE_SET_O(lls),
		.POWER_GOOD_O(pg), .LATCHOFF_O(latch)
	);

	sts_pins_model u_pins (
		.clk_i(clk), .rst_b_i(rst_b), .tie_i(tie), .drive_i(drive), .oe_i(oe), .pulldown_i(pd),
		.above_o(above)
	);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	task final_report();
		if (mismatches == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// A wait that used up its bound is a failure in itself
	task automatic guard(input int cnt_n, input int lim);
		if (cnt_n >= lim) begin
			mismatches++;
			final_report();
		end
	endtask

	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		@(posedge clk);
		cmd_wr <= 1'b1;
		cmd_code <= c;
		cmd_wdata <= d;
		@(posedge clk);
		cmd_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] c, input logic [7:0] e);
		@(posedge clk);
		cmd_rd <= 1'b1;
		cmd_code <= c;
		exp_q.push_back(e);
		@(posedge clk);
		cmd_rd <= 1'b0;
	endtask

	// Read data lands one edge after the read is taken
	always @(posedge clk) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) begin
				check(32'h1, 32'h0);
			end else begin
				check(rdata, exp_q.pop_front());
			end
		end
		rd_seen = cmd_rd;
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		check(cnt, 3'h4);
		check(trim, 5'h10);
		check({llc, lls}, 10'h210);
		check({dac, pg, latch}, 10'h000);
		rd(8'hd4, 8'h03);
		rd(8'hd5, 8'h02);
		rd(8'he2, 8'h10);
		rd(8'hde, 8'h10);
		rd(8'h55, 8'h00);
		v = xs();
		sense <= v[7:0];
		rd(8'h8c, v[7:0]);
		// Random codes: upper bits dropped, copies follow the write
		for (i = 0; i < 3; i++) begin
			v = xs();
			wr(codes[i], v[7:0]);
			rd(codes[i], {3'h0, v[4:0]});
			@(posedge clk);
			check(i == 0 ? trim : (i == 1 ? llc : lls), v[4:0]);
		end
		// Enable alone must not start while the supply is locked out
		lock <= 1'b1;
		en <= 1'b1;
		repeat (100) @(posedge clk);
		check({dac, pg}, 9'h000);
		en <= 1'b0;
		lock <= 1'b0;
		repeat (4) @(posedge clk);
		for (k = 0; k < 4; k++) begin
			wr(8'hd4, {5'h1f, dlys[k]});
			rd(8'hd4, {5'h00, dlys[k]});
			wr(8'hd5, {5'h1f, slews[k]});
			tie <= ties[k];
			// Last run targets above the boot level so the final ramp climbs
			voltage_id_code <= (k == 3) ? 8'hc0 : 8'h80;
			act = {~ties[k][3:1], 1'b1};
			en <= 1'b1;
			t0 = 0;
			t1 = 0;
			tp = 0;
			pv = 8'h00;
			for (n = 1; n < LIM && tp == 0; n++) begin
				@(posedge clk);
				if (dac !== pv) begin
					check((dac == pv + 8'h01) || (dac == pv - 8'h01), 1);
					pv = dac;
				end
				if (t0 == 0 && dac === 8'h01) t0 = n;
				if (t1 == 0 && dac === 8'ha8) t1 = n;
				if (pg === 1'b1) tp = n;
			end
			guard(n, LIM);
			check(t1 - t0, 167 * (BASE / (2 * slews[k] + 1)));
			check(dac, (k == 3) ? 8'hc0 : 8'h80);
			check(cnt, cnts[k]);
			check(oe, act);
			check(pd, 4'h0);
			if (k == 0) begin
				b0 = t0;
				bp = tp;
			end
			if (k == 1) begin
				check(t0 - b0, 7 * STEP);
				check(tp - bp, 3 * 7 * STEP);
			end
			// Slot rotation over the active phases only
			for (i = 0; i < 8; i++) begin
				@(posedge clk);
				sl_a[i] = slot;
			end
			for (i = 0; i < 8; i++) begin
				check(sl_a[i] & ~act, 4'h0);
				check($countones(sl_a[i]), 1);
				if (i + cnts[k] < 8) check(sl_a[i + cnts[k]], sl_a[i]);
				if (cnts[k] > 1 && i < 7) check(sl_a[i + 1] !== sl_a[i], 1);
			end
			v = xs();
			req <= v[3:0];
			repeat (3) @(posedge clk);
			check(drive & oe, v[3:0] & act);
			if (k == 0) begin
				climit <= 1'b1;
				for (n = 0; n < 400 && latch !== 1'b1; n++) @(posedge clk);
				guard(n, 400);
				check(n >= 4 * STEP && n <= 4 * STEP + 10, 1);
				climit <= 1'b0;
			end
			if (k == 2) begin
				climit <= 1'b1;
				repeat (20) @(posedge clk);
				climit <= 1'b0;
				repeat (150) @(posedge clk);
				check({latch, pg}, 2'b01);
			end
			en <= 1'b0;
			req <= 4'h0;
			repeat (6) @(posedge clk);
			check({dac, pg, latch}, 10'h000);
		end
		final_report();
	end
endmodule
